/* File: dbc_host.sv */
// Host model: strobed byte reads and writes on the board's I/O bus.
// Assumes the board synchronises strobes; all timing counts mclk edges.
`timescale 1ns/100ps
`default_nettype none

module dbc_host import dbc_pkg::*; #(
  parameter logic [15:0] BASE_ADDR = 16'h0300
) (
  // Clock
  input  wire logic        mclk,
  // Bus
  output logic      [15:0] io_addr,
  output logic             io_ior_n,
  output logic             io_iow_n,
  output logic      [7:0]  io_data_in,
  input  wire logic [7:0]  io_data_out,
  input  wire logic        io_data_oe_n
);
  initial begin
    io_addr    = BASE_ADDR;
    io_ior_n   = 1'b1;
    io_iow_n   = 1'b1;
    io_data_in = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setup, low and high times all exceed the four-edge sync window
  task automatic cyc(input logic [15:0] ofs, input logic wr,
                     input logic [7:0] wd, output logic [7:0] rd,
                     output logic drv);
    rd  = 8'h00;
    drv = 1'b0;
    @(posedge mclk);
    #1;
    io_addr    = BASE_ADDR + ofs;
    io_data_in = wd;
    repeat (6) @(posedge mclk);
    #1;
    if (wr) io_iow_n = 1'b0;
    else io_ior_n = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge mclk);
      if (!wr && i >= 4 && io_data_oe_n === 1'b0) begin
        rd  = io_data_out;
        drv = 1'b1;
        break;
      end
    end
    #1;
    io_iow_n = 1'b1;
    io_ior_n = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    // Released data lines never keep the last byte
    io_data_in = ~wd;
  endtask

  task automatic wr(input logic [15:0] ofs, input logic [7:0] d);
    logic [7:0] r;
    logic       v;
    cyc(ofs, 1'b1, d, r, v);
  endtask

  task automatic rd(input logic [15:0] ofs, output logic [7:0] r,
                    output logic v);
    cyc(ofs, 1'b0, 8'h00, r, v);
  endtask

  // Pointer first, upper five bits zero
  task automatic ireg_wr(input logic [2:0] idx, input logic [7:0] d);
    wr(OFS_INDEX, {5'h00, idx});
    wr(OFS_INDEXED_DATA, d);
  endtask

  task automatic ireg_rd(input logic [2:0] idx, output logic [7:0] r,
                         output logic v);
    wr(OFS_INDEX, {5'h00, idx});
    rd(OFS_INDEXED_DATA, r, v);
  endtask
endmodule

`default_nettype wire

/* File: dbc_pkg.sv */
// Shared constants and carriers for the acquisition board control block.
// Assumes an 8-bit I/O bus with 16-bit addresses, decoded against a base.
`default_nettype none

package dbc_pkg;

  // Byte offsets from the board base address
  localparam logic [15:0] OFS_INDEX        = 16'h0002;
  localparam logic [15:0] OFS_INDEXED_DATA = 16'h0003;
  localparam logic [15:0] OFS_STATUS       = 16'h0004;
  localparam logic [15:0] OFS_IRQ_FLAGS    = 16'h0005;
  localparam logic [15:0] OFS_DIO          = 16'h0006;
  localparam logic [15:0] OFS_DAC0_LO      = 16'h0008;
  localparam logic [15:0] OFS_DAC0_HI      = 16'h0009;
  localparam logic [15:0] OFS_THRESHOLD_ANALOG_OUTPUT_LO      = 16'h000A;
  localparam logic [15:0] OFS_THRESHOLD_ANALOG_OUTPUT_HI      = 16'h000B;
  localparam logic [15:0] OFS_BOARD_SWITCH = 16'h8000;

  // Indirect register numbers
  localparam logic [2:0] IDX_CONFIG  = 3'h0;
  localparam logic [2:0] IDX_IRQ_DMA = 3'h1;
  localparam logic [2:0] IDX_AUX     = 3'h2;
  localparam logic [2:0] IDX_IRQ_EN  = 3'h3;
  localparam logic [4:0] INDEX_READ_TAG = 5'h1E;

  // Field positions
  localparam int CFG_DMA_EN = 7, CFG_DMA_MULTI = 6, CFG_DMA_SRC = 5;
  localparam int CFG_DAC_CH = 4, CFG_DIGITAL = 3, CFG_SINGLE = 2;
  localparam int CFG_INTERNAL = 1, CFG_RISING = 0;
  localparam int AUX_SWTRIG = 7, AUX_FLUSH_SCAN = 6, AUX_FLUSH_DATA = 5;
  localparam int AUX_STOP = 3, AUX_DMA_OFF = 2;
  localparam int IE_GLOBAL = 7;
  localparam int ST_EOC = 7, ST_UNIPOLAR = 6, ST_SE = 5, ST_EMPTY = 4;
  localparam int ST_HALF = 3, ST_FULL = 2, ST_BUSY = 1, ST_ARM = 0;
  localparam int DIO_ALT_TRIG = 5, DIO_EXP_EN = 4;
  localparam int FLG_TC = 5, FLG_TMR0 = 4, FLG_TRIG = 3;
  localparam int FLG_FULL = 2, FLG_HALF = 1, FLG_EOS = 0;

  // Values after reset
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] RST_IRQ_DMA  = 8'h0F;
  localparam logic       RST_BOARD_ON = 1'b1;
  localparam logic [1:0] DMA_NONE     = 2'h3;

  typedef enum logic [2:0] {
    SC_IDLE  = 3'b001,
    SC_ARMED = 3'b010,
    SC_RUN   = 3'b100
  } dbc_scan_e;

  // State reported by the acquisition core, same clock
  typedef struct packed {
    logic       eoc;
    logic       fifo_empty;
    logic       fifo_half;
    logic       fifo_full;
    logic       scan_active;
    logic       scan_done;
    logic       terminal_count;
    logic       timer0_event;
    logic       analog_above;
    logic       dma_cur_chan;
    logic [1:0] scan_speed;
  } dbc_acq_stat_s;

  // Controls handed to the acquisition core
  typedef struct packed {
    logic scan_run;
    logic start_pulse;
    logic sw_trigger;
    logic flush_scan;
    logic flush_data;
    logic dma_en;
    logic dma_multi;
    logic dma_src_dac;
    logic dma_dac_chan;
    logic unipolar;
    logic single_ended;
    logic exp_enable;
    logic board_enabled;
  } dbc_acq_ctl_s;

endpackage

`default_nettype wire

/* File: dbc_regs.sv */
// Host-visible control and status logic of the acquisition board.
// Assumes bus strobes, address and data arrive asynchronously to mclk.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Three-stage pin synchroniser; level moves once stages two and three agree
module dbc_sync #(
  parameter int              W    = 1,
  parameter logic [W-1:0]    INIT = '0
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_q    <= INIT;
      s2_q    <= INIT;
      s3_q    <= INIT;
      level_q <= INIT;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Operation
// [R1] Index write selects register by low three bits
// [R2] Index read returns 11110 and index
// [R3] Indexed data access goes to selected register
// [R4] Config bits control DMA enable, mode, source
// [R5] Config bits choose trigger kind, mode, edge
// [R6] Digital trigger pin chosen by DIO bit 5
// [R7] IRQ code and two DMA channel codes decoded
// [R8] Aux command: soft trigger, flush FIFOs
// [R9] Host flushes both FIFOs before acquisition
// [R10] Stop request ends continuous scan after sequence
// [R11] DMA off request waits for terminal count
// [R12] Interrupt enables: global plus six sources
// [R13] Sticky source flags read in bits 5-0
// [R14] Status reads EOC, FIFO levels, busy
// [R15] Unipolar and single-ended selections read back
// [R16] Status bit 0 arms or disarms conversion
// [R17] DIO bits 7-6 read scan speed
// [R18] DIO bit 4 enables expansion board lines
// [R19] DIO low nibble: output write, input read
// [R20] Board switch read disables, write enables
// [R21] Analog trigger compares start channel with threshold
// [R22] Selected IRQ line asserted on enabled flag
module dbc_regs import dbc_pkg::*; #(
  parameter logic [15:0] BASE_ADDR = 16'h0300
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          nrst,
  // I/O bus
  input  wire logic [15:0]   io_addr,
  input  wire logic          io_ior_n,
  input  wire logic          io_iow_n,
  input  wire logic [7:0]    io_data_in,
  output logic      [7:0]    io_data_out,
  output logic               io_data_oe_n,
  output logic      [15:0]   irq_lines,
  output logic      [2:0]    dma_chan_a,
  output logic      [2:0]    dma_chan_b,
  // Acquisition core
  input  wire dbc_acq_stat_s acq_stat,
  output dbc_acq_ctl_s       acq_ctl,
  output logic      [15:0]   analog_out0_value,
  output logic      [15:0]   threshold_analog_output,
  // Connector pins
  input  wire logic          ext_clock_input_pin,
  input  wire logic          alt_trigger_input_pin,
  input  wire logic [3:0]    dio_in,
  output logic      [3:0]    dio_out
);

  logic [15:0]  addr_s;
  logic [7:0]   data_s;
  logic [1:0]   strb_s;
  logic [5:0]   pin_s;
  logic [1:0]   strb_prev_q;
  logic         rd_stb;
  logic         wr_stb;
  logic [15:0]  ofs;
  logic [2:0]   index_q;
  logic [7:0]   config_q;
  logic [7:0]   irq_dma_q;
  logic [7:0]   irq_en_q;
  logic [5:0]   flags_q;
  logic         unipolar_q;
  logic         single_ended_q;
  logic [7:0]   dio_ctl_q;
  logic         board_on_q;
  logic         dma_off_pend_q;
  logic         stop_pend_q;
  logic [7:0]   aux_pulse_q;
  logic         trig_prev_q;
  logic         ana_prev_q;
  logic         half_prev_q;
  logic         full_prev_q;
  logic         trig_hit;
  logic         trig_lvl;
  logic         cfg_wr;
  logic         aux_wr;
  dbc_scan_e    scan_q;
  logic [7:0]   rd_mux;
  logic         rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Bus and pin synchronisers
  dbc_sync #(.W(16), .INIT(16'h0000)) u_sync_addr (
    .mclk(mclk), .nrst(nrst), .pin(io_addr), .level_q(addr_s));
  dbc_sync #(.W(8), .INIT(8'h00)) u_sync_data (
    .mclk(mclk), .nrst(nrst), .pin(io_data_in), .level_q(data_s));
  dbc_sync #(.W(2), .INIT(2'h3)) u_sync_strb (
    .mclk(mclk), .nrst(nrst), .pin({io_ior_n, io_iow_n}), .level_q(strb_s));
  dbc_sync #(.W(6), .INIT(6'h00)) u_sync_pins (
    .mclk(mclk), .nrst(nrst),
    .pin({ext_clock_input_pin, alt_trigger_input_pin, dio_in}),
    .level_q(pin_s));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      strb_prev_q <= 2'h3;
    end else begin
      strb_prev_q <= strb_s;
    end
  end

  // Strobes act once per bus cycle, on the falling edge
  assign rd_stb = strb_prev_q[1] & ~strb_s[1];
  assign wr_stb = strb_prev_q[0] & ~strb_s[0];
  assign ofs    = addr_s - BASE_ADDR;
  // Disabled board answers only at its switch address
  assign cfg_wr = wr_stb & board_on_q & (ofs == OFS_INDEXED_DATA)
                  & (index_q == IDX_CONFIG);
  assign aux_wr = wr_stb & board_on_q & (ofs == OFS_INDEXED_DATA)
                  & (index_q == IDX_AUX);

  ////////////////////////////////////////////////////////////////////////////
  // Directly addressed registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      index_q           <= 3'h0;
      unipolar_q        <= 1'b0;
      single_ended_q    <= 1'b0;
      dio_ctl_q         <= RST_BYTE;
      analog_out0_value <= 16'h0000;
      threshold_analog_output <= 16'h0000;
    end else if (wr_stb && board_on_q) begin
      case (ofs)
        OFS_INDEX: index_q <= data_s[2:0];                // [R1]
        OFS_STATUS: begin
          unipolar_q     <= data_s[ST_UNIPOLAR];          // [R15]
          single_ended_q <= data_s[ST_SE];                // [R15]
        end
        OFS_DIO:     dio_ctl_q <= data_s;                 // [R6] [R18] [R19]
        OFS_DAC0_LO: analog_out0_value[7:0]  <= data_s;
        OFS_DAC0_HI: analog_out0_value[15:8] <= data_s;
        OFS_THRESHOLD_ANALOG_OUTPUT_LO: threshold_analog_output[7:0]  <= data_s; // [R21]
        OFS_THRESHOLD_ANALOG_OUTPUT_HI: threshold_analog_output[15:8] <= data_s; // [R21]
        default: ;
      endcase
    end
  end

  // Board switch: read turns off, write turns on
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      board_on_q <= RST_BOARD_ON;
    end else if (ofs == OFS_BOARD_SWITCH) begin
      if (wr_stb) begin
        board_on_q <= 1'b1;                               // [R20]
      end else if (rd_stb) begin
        board_on_q <= 1'b0;                               // [R20]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indirect registers behind the index pointer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_dma_q <= RST_IRQ_DMA;
      irq_en_q  <= RST_BYTE;
    end else if (wr_stb && board_on_q && ofs == OFS_INDEXED_DATA) begin
      case (index_q)                                      // [R3]
        IDX_IRQ_DMA: irq_dma_q <= data_s;                 // [R7]
        IDX_IRQ_EN:  irq_en_q  <= data_s;                 // [R12]
        default: ;
      endcase
    end
  end

  // DMA enable drops at the terminal count after an off request
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      config_q       <= RST_BYTE;
      dma_off_pend_q <= 1'b0;
    end else begin
      if (cfg_wr) begin
        config_q <= data_s;                               // [R4] [R5]
      end else if (dma_off_pend_q && acq_stat.terminal_count) begin
        config_q[CFG_DMA_EN] <= 1'b0;                     // [R11]
      end
      if (aux_wr && data_s[AUX_DMA_OFF]) begin
        dma_off_pend_q <= 1'b1;                           // [R11]
      end else if (acq_stat.terminal_count) begin
        dma_off_pend_q <= 1'b0;
      end
    end
  end

  // Aux command bits are one-cycle actions; zeros do nothing
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aux_pulse_q <= RST_BYTE;
    end else begin
      aux_pulse_q <= aux_wr ? data_s : RST_BYTE;          // [R8] [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger detection and scan sequencing
  assign trig_lvl = dio_ctl_q[DIO_ALT_TRIG] ? pin_s[4] : pin_s[5]; // [R6]

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      trig_prev_q <= 1'b0;
      ana_prev_q  <= 1'b0;
    end else begin
      trig_prev_q <= trig_lvl;
      ana_prev_q  <= acq_stat.analog_above;
    end
  end

  // Soft trigger always counts; otherwise the configured source and edge
  always_comb begin
    trig_hit = aux_pulse_q[AUX_SWTRIG];                   // [R8]
    if (!config_q[CFG_INTERNAL]) begin
      if (config_q[CFG_DIGITAL]) begin
        trig_hit = trig_hit | (config_q[CFG_RISING]
                   ? (trig_lvl & ~trig_prev_q)
                   : (~trig_lvl & trig_prev_q));          // [R5]
      end else begin
        trig_hit = trig_hit | (config_q[CFG_RISING]
                   ? (acq_stat.analog_above & ~ana_prev_q)
                   : (~acq_stat.analog_above & ana_prev_q)); // [R21]
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scan_q      <= SC_IDLE;
      stop_pend_q <= 1'b0;
    end else begin
      if (aux_pulse_q[AUX_STOP] && scan_q == SC_RUN) begin
        stop_pend_q <= 1'b1;                              // [R10]
      end else if (scan_q != SC_RUN) begin
        stop_pend_q <= 1'b0;
      end
      if (wr_stb && board_on_q && ofs == OFS_STATUS) begin
        scan_q <= data_s[ST_ARM] ? ((scan_q == SC_RUN) ? SC_RUN : SC_ARMED)
                                 : SC_IDLE;               // [R16]
      end else begin
        case (scan_q)
          SC_IDLE: scan_q <= SC_IDLE;
          SC_ARMED: begin
            if (trig_hit && board_on_q) begin
              scan_q <= SC_RUN;
            end
          end
          SC_RUN: begin
            if (acq_stat.scan_done) begin
              if (config_q[CFG_SINGLE]) begin
                scan_q <= SC_IDLE;
              end else if (stop_pend_q) begin
                scan_q <= SC_ARMED;                       // [R10]
              end
            end
          end
          default: scan_q <= SC_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky source flags, cleared by reading them; a new event wins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flags_q     <= 6'h00;
      half_prev_q <= 1'b0;
      full_prev_q <= 1'b0;
    end else begin
      half_prev_q <= acq_stat.fifo_half;
      full_prev_q <= acq_stat.fifo_full;
      flags_q <= ((rd_stb && board_on_q && ofs == OFS_IRQ_FLAGS)
                  ? 6'h00 : flags_q)
               | {acq_stat.terminal_count, acq_stat.timer0_event,
                  (scan_q == SC_ARMED) & trig_hit,
                  acq_stat.fifo_full & ~full_prev_q,
                  acq_stat.fifo_half & ~half_prev_q,
                  acq_stat.scan_done};                    // [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured at the read edge and held for the cycle
  always_comb begin
    rd_mux = 8'h00;
    rd_hit = board_on_q;
    case (ofs)
      OFS_INDEX: rd_mux = {INDEX_READ_TAG, index_q};      // [R2]
      OFS_INDEXED_DATA: begin
        case (index_q)
          IDX_CONFIG: begin
            rd_mux = config_q;
            rd_mux[CFG_DMA_MULTI] = acq_stat.dma_cur_chan; // [R4]
          end
          IDX_IRQ_DMA: rd_mux = irq_dma_q;
          IDX_AUX:     rd_mux = 8'h00;
          IDX_IRQ_EN:  rd_mux = irq_en_q;
          default:     rd_hit = 1'b0;  // Timer lives elsewhere
        endcase
      end
      OFS_STATUS: rd_mux = {acq_stat.eoc, unipolar_q, single_ended_q,
                            acq_stat.fifo_empty, acq_stat.fifo_half,
                            acq_stat.fifo_full, acq_stat.scan_active,
                            scan_q != SC_IDLE};           // [R14] [R15] [R16]
      OFS_IRQ_FLAGS: rd_mux = {2'h0, flags_q};            // [R13]
      OFS_DIO: rd_mux = {acq_stat.scan_speed, dio_ctl_q[5:4],
                         pin_s[3:0]};                     // [R17] [R19]
      OFS_BOARD_SWITCH: rd_mux = 8'h00;
      default: rd_hit = 1'b0;
    endcase
    if (ofs == OFS_BOARD_SWITCH) begin
      rd_hit = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      io_data_out  <= 8'h00;
      io_data_oe_n <= 1'b1;
    end else if (rd_stb) begin
      io_data_out  <= rd_mux;
      io_data_oe_n <= ~rd_hit;
    end else if (strb_s[1]) begin
      io_data_oe_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt line and DMA channel decode
  function automatic logic [2:0] dma_dec(input logic [1:0] code);
    dma_dec = (code == DMA_NONE) ? 3'h0 : 3'(3'h1 << code);
  endfunction

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_lines  <= 16'h0000;
      dma_chan_a <= 3'h0;
      dma_chan_b <= 3'h0;
    end else begin
      irq_lines <= 16'h0000;
      if (board_on_q && irq_en_q[IE_GLOBAL]
          && |(flags_q & irq_en_q[5:0])) begin            // [R12] [R22]
        case (irq_dma_q[7:4])                             // [R7]
          4'h0, 4'h1, 4'h2, 4'h8, 4'hD: irq_lines <= 16'h0000;
          default: irq_lines <= 16'(16'h1 << irq_dma_q[7:4]);
        endcase
      end
      dma_chan_a <= dma_dec(irq_dma_q[3:2]);              // [R7]
      dma_chan_b <= dma_dec(irq_dma_q[1:0]);              // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered controls to the core and the connector
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acq_ctl <= '0;
      dio_out <= 4'h0;
    end else begin
      acq_ctl.scan_run      <= (scan_q == SC_RUN);
      acq_ctl.start_pulse   <= (scan_q == SC_ARMED) & trig_hit & board_on_q;
      acq_ctl.sw_trigger    <= aux_pulse_q[AUX_SWTRIG];
      acq_ctl.flush_scan    <= aux_pulse_q[AUX_FLUSH_SCAN];  // [R8]
      acq_ctl.flush_data    <= aux_pulse_q[AUX_FLUSH_DATA];  // [R8]
      acq_ctl.dma_en        <= config_q[CFG_DMA_EN];         // [R4]
      acq_ctl.dma_multi     <= config_q[CFG_DMA_MULTI];
      acq_ctl.dma_src_dac   <= config_q[CFG_DMA_SRC];
      acq_ctl.dma_dac_chan  <= config_q[CFG_DAC_CH];
      acq_ctl.unipolar      <= unipolar_q;
      acq_ctl.single_ended  <= single_ended_q;
      acq_ctl.exp_enable    <= dio_ctl_q[DIO_EXP_EN];        // [R18]
      acq_ctl.board_enabled <= board_on_q;
      dio_out               <= dio_ctl_q[3:0];               // [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_aux_flush;
    aux_wr && data_s[AUX_FLUSH_SCAN];
  endsequence

  AST_INDEX_WRITE: assert property (                        // [R1]
    wr_stb && board_on_q && ofs == OFS_INDEX |=> index_q == $past(data_s[2:0]))
    else $error("index pointer not loaded");
  AST_INDEX_READ: assert property (                         // [R2]
    rd_stb && board_on_q && ofs == OFS_INDEX
    |=> io_data_out == {INDEX_READ_TAG, index_q} && !io_data_oe_n)
    else $error("index readback wrong");
  AST_STEER: assert property (                              // [R3]
    wr_stb && board_on_q && ofs == OFS_INDEXED_DATA && index_q == IDX_IRQ_EN
    |=> irq_en_q == $past(data_s))
    else $error("indexed write misrouted");
  AST_CFG_OUT: assert property (                            // [R4]
    cfg_wr |=> ##1 acq_ctl.dma_src_dac == $past(data_s[CFG_DMA_SRC], 2))
    else $error("config not forwarded");
  AST_FLUSH: assert property (                              // [R8]
    s_aux_flush |=> ##1 acq_ctl.flush_scan ##1 !acq_ctl.flush_scan
                    || aux_pulse_q[AUX_FLUSH_SCAN])
    else $error("scan flush pulse wrong");
  AST_STOP_DEFER: assert property (                         // [R10]
    scan_q == SC_RUN && !acq_stat.scan_done && !wr_stb |=> scan_q == SC_RUN)
    else $error("scan ended before sequence done");
  AST_DMA_TC: assert property (                             // [R11]
    config_q[CFG_DMA_EN] && !acq_stat.terminal_count && !cfg_wr
    |=> config_q[CFG_DMA_EN])
    else $error("DMA dropped without terminal count");
  AST_FLAG_SET: assert property (                           // [R13]
    acq_stat.timer0_event |=> flags_q[FLG_TMR0])
    else $error("timer flag lost");
  AST_IRQ: assert property (                                // [R22]
    |irq_lines |-> $past(irq_en_q[IE_GLOBAL]) && $past(board_on_q))
    else $error("IRQ without global enable");
  AST_BOARD: assert property (                              // [R20]
    rd_stb && !wr_stb && ofs == OFS_BOARD_SWITCH |=> !board_on_q)
    else $error("board not disabled by read");

endmodule

`default_nettype wire

/* File: tb_daq_board_control_registers.sv */
// Self-checking bench for the board control registers.
// Assumes dbc_host drives the bus; the bench plays the acquisition core.
`timescale 1ns/100ps
`default_nettype none

`define CHK(what, exp, got) begin num_checks++; \
  if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", what, exp, got); end end

module tb_daq_board_control_registers import dbc_pkg::*;;
  logic          mclk, nrst, io_ior_n, io_iow_n, io_data_oe_n, drv, alt_pin;
  logic [15:0]   io_addr, irq_lines, dac0, thr;
  logic [7:0]    io_data_in, io_data_out, rv;
  logic [2:0]    dma_a, dma_b;
  logic [3:0]    dio_in, dio_out;
  dbc_acq_stat_s acq_stat;
  dbc_acq_ctl_s  acq_ctl;
  int            n_fail, num_checks, cycles, n_trig, n_fs, n_fd;

  dbc_regs dut (.mclk(mclk), .nrst(nrst), .io_addr(io_addr),
    .io_ior_n(io_ior_n), .io_iow_n(io_iow_n), .io_data_in(io_data_in),
    .io_data_out(io_data_out), .io_data_oe_n(io_data_oe_n),
    .irq_lines(irq_lines), .dma_chan_a(dma_a), .dma_chan_b(dma_b),
    .acq_stat(acq_stat), .acq_ctl(acq_ctl), .analog_out0_value(dac0),
    .threshold_analog_output(thr), .ext_clock_input_pin(1'b0),
    .alt_trigger_input_pin(alt_pin), .dio_in(dio_in), .dio_out(dio_out));
  dbc_host host (.mclk(mclk), .io_addr(io_addr), .io_ior_n(io_ior_n),
    .io_iow_n(io_iow_n), .io_data_in(io_data_in),
    .io_data_out(io_data_out), .io_data_oe_n(io_data_oe_n));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Pulse outputs are one cycle wide, so count them as they pass
  always @(posedge mclk) begin
    cycles++;
    if (acq_ctl.sw_trigger === 1'b1) n_trig++;
    if (acq_ctl.flush_scan === 1'b1) n_fs++;
    if (acq_ctl.flush_data === 1'b1) n_fd++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic pulse(input logic [11:0] m);
    @(posedge mclk);
    #1;
    acq_stat = acq_stat | m;
    @(posedge mclk);
    #1;
    acq_stat = acq_stat & ~m;
    // Registered controls follow state one edge later
    repeat (2) @(posedge mclk);
    #1;
  endtask

  function automatic logic [2:0] dma_exp(input logic [1:0] d);
    dma_exp = (d == 2'h3) ? 3'h0 : 3'h1 << d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    acq_stat = 12'hC00;
    dio_in = 4'h5;
    alt_pin = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    nrst = 1'b1;
    repeat (6) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      host.wr(OFS_INDEX, {5'h00, 3'(i)});
      host.rd(OFS_INDEX, rv, drv);
      `CHK("index", {5'h1E, 3'(i)}, rv)
    end
    host.ireg_wr(IDX_CONFIG, 8'hB6);
    `CHK("dma", 4'hB, {acq_ctl.dma_en, acq_ctl.dma_multi,
                       acq_ctl.dma_src_dac, acq_ctl.dma_dac_chan})
    acq_stat.dma_cur_chan = 1'b1;
    host.ireg_rd(IDX_CONFIG, rv, drv);
    `CHK("cfg", 8'hF6, rv)
    host.ireg_wr(IDX_AUX, 8'h60);
    `CHK("flush", 3'h2, 3'(n_fs + n_fd + n_trig))
    host.wr(OFS_STATUS, 8'h61);
    host.rd(OFS_STATUS, rv, drv);
    `CHK("status", 8'hF1, rv)
    host.ireg_wr(IDX_AUX, 8'h80);
    `CHK("swtrig", 2'h3, {1'(n_trig), acq_ctl.scan_run})
    acq_stat.scan_active = 1'b1;
    host.rd(OFS_STATUS, rv, drv);
    `CHK("busy", 8'hF3, rv)
    pulse(12'h040);
    `CHK("single", 1'b0, acq_ctl.scan_run)
    host.rd(OFS_IRQ_FLAGS, rv, drv);
    `CHK("flags0", 8'h09, rv)
    host.ireg_wr(IDX_IRQ_EN, 8'h90);
    pulse(12'h010);
    for (int c = 0; c < 16; c++) begin
      host.ireg_wr(IDX_IRQ_DMA, {4'(c), 2'(c), ~2'(c)});
      `CHK("irq", (c inside {0, 1, 2, 8, 13}) ? 16'h0 : 16'h1 << c,
           irq_lines)
      `CHK("dma_ab", {dma_exp(2'(c)), dma_exp(~2'(c))}, {dma_a, dma_b})
    end
    host.ireg_wr(IDX_IRQ_EN, 8'h10);
    `CHK("global", 16'h0, irq_lines)
    host.ireg_wr(IDX_IRQ_EN, 8'h90);
    host.rd(OFS_IRQ_FLAGS, rv, drv);
    `CHK("flags", 8'h10, rv)
    `CHK("irq_clr", 16'h0, irq_lines)
    host.ireg_wr(IDX_AUX, 8'h04);
    `CHK("dma_hold", 1'b1, acq_ctl.dma_en)
    pulse(12'h020);
    `CHK("dma_off", 1'b0, acq_ctl.dma_en)
    acq_stat.scan_speed = 2'h2;
    host.wr(OFS_DIO, 8'h1A);
    `CHK("dio_out", 5'h1A, {acq_ctl.exp_enable, dio_out})
    host.rd(OFS_DIO, rv, drv);
    `CHK("dio_rd", 8'h85, rv & 8'hCF)
    host.wr(OFS_THRESHOLD_ANALOG_OUTPUT_LO, 8'h34);
    host.wr(OFS_THRESHOLD_ANALOG_OUTPUT_HI, 8'h12);
    `CHK("thr", 16'h1234, thr)
    // Continuous analog trigger, then a deferred stop
    host.ireg_wr(IDX_CONFIG, 8'h01);
    host.wr(OFS_STATUS, 8'h61);
    acq_stat.analog_above = 1'b1;
    pulse(12'h040);
    `CHK("cont", 1'b1, acq_ctl.scan_run)
    host.ireg_wr(IDX_AUX, 8'h08);
    `CHK("stop_wait", 1'b1, acq_ctl.scan_run)
    pulse(12'h040);
    host.rd(OFS_STATUS, rv, drv);
    `CHK("stop", 2'h1, {acq_ctl.scan_run, rv[0]})
    // Digital trigger taken from the alternate pin
    host.wr(OFS_DIO, 8'h3A);
    host.ireg_wr(IDX_CONFIG, 8'h09);
    alt_pin = 1'b1;
    repeat (8) @(posedge mclk);
    `CHK("alt_trig", 1'b1, acq_ctl.scan_run)
    host.wr(OFS_STATUS, 8'h60);
    host.rd(OFS_STATUS, rv, drv);
    `CHK("disarm", 2'h0, {acq_ctl.scan_run, rv[0]})
    host.rd(16'h0007, rv, drv);
    `CHK("unmapped", 1'b0, drv)
    host.rd(OFS_BOARD_SWITCH, rv, drv);
    host.rd(OFS_INDEX, rv, drv);
    `CHK("off", 2'h0, {acq_ctl.board_enabled, drv})
    host.wr(OFS_BOARD_SWITCH, 8'h00);
    `CHK("on", 1'b1, acq_ctl.board_enabled)
    finish_test();
  end
endmodule

`default_nettype wire
